/* File: hw/evp_pkg.sv */
// Package with constants and types of the exception vector priority unit
package evp_pkg;
  localparam int          VEC_W         = 16;
  localparam int          BASE_W        = 8;
  localparam int          NUM_IRQ       = 57;
  localparam logic [7:0]  BASE_RST      = 8'hFF;
  localparam logic [7:0]  BASE_DEBUG    = 8'hFF;
  localparam logic [7:0]  BASE_LOW      = 8'h00;
  localparam logic [15:0] OFS_SPURIOUS  = 16'h0080;
  localparam logic [15:0] OFS_IRQ_LOW   = 16'h0082;
  localparam logic [15:0] OFS_IRQ_HIGH  = 16'h00F2;
  localparam logic [15:0] OFS_XIRQ      = 16'h00F4;
  localparam logic [15:0] OFS_SWI       = 16'h00F6;
  localparam logic [15:0] OFS_TRAP      = 16'h00F8;
  localparam logic [15:0] VEC_RST_COP   = 16'hFFFA;
  localparam logic [15:0] VEC_RST_CLK   = 16'hFFFC;
  localparam logic [15:0] VEC_RST_POR   = 16'hFFFE;
  localparam logic [15:0] VEC_RST_VAL   = 16'h0000;

  typedef enum logic [1:0] {
    EVP_IDLE = 2'b00,
    EVP_HOLD = 2'b01
  } evp_state_t;
endpackage : evp_pkg

/* File: hw/evp_dec_if.sv */
// Interface between the vector unit top and its priority decoder
`timescale 1ns/1ps
`default_nettype none
interface evp_dec_if;
  logic [56:0] irq_req;
  logic        xirq_req;
  logic        swi_req;
  logic        trap_req;
  logic [1:0]  rst_sel;
  logic        rst_req;
  logic [7:0]  base;
  logic [15:0] vector;
  logic        any_req;

  modport top (output irq_req, output xirq_req, output swi_req,
               output trap_req, output rst_sel, output rst_req,
               output base, input vector, input any_req);
  modport dec (input irq_req, input xirq_req, input swi_req,
               input trap_req, input rst_sel, input rst_req,
               input base, output vector, output any_req);
endinterface : evp_dec_if
`default_nettype wire

/* File: hw/evp_prio_dec.sv */
// Combinational priority decoder that picks the winning exception vector
`timescale 1ns/1ps
`default_nettype none
module evp_prio_dec (
  evp_dec_if.dec d
);
  // Join base byte and a vector offset into a full address
  function automatic logic [15:0] evp_join(input logic [7:0]  base,
                                           input logic [15:0] ofs);
    evp_join = {base, evp_pkg::BASE_LOW} | ofs;
  endfunction

  logic [15:0] vec_c;
  logic        any_c;

  // Fixed order: resets, trap, swi, xirq, then maskable, spurious
  always_comb begin
    vec_c = evp_join(d.base, evp_pkg::OFS_SPURIOUS);
    any_c = 1'b0;
    // Lowest index first so the highest vector address is written last
    for (int i = 0; i < evp_pkg::NUM_IRQ; i++) begin
      if (d.irq_req[i]) begin
        vec_c = evp_join(d.base, evp_pkg::OFS_IRQ_LOW +
                         16'(2 * i));
        any_c = 1'b1;
      end
    end
    // Nonmaskable and X requests outrank every maskable one
    if (d.xirq_req) begin
      vec_c = evp_join(d.base, evp_pkg::OFS_XIRQ);
      any_c = 1'b1;
    end
    if (d.swi_req) begin
      vec_c = evp_join(d.base, evp_pkg::OFS_SWI);
      any_c = 1'b1;
    end
    if (d.trap_req) begin
      vec_c = evp_join(d.base, evp_pkg::OFS_TRAP);
      any_c = 1'b1;
    end
    // Reset vectors ignore the base byte entirely
    if (d.rst_req) begin
      any_c = 1'b1;
      case (d.rst_sel)
        2'h1:    vec_c = evp_pkg::VEC_RST_CLK;
        2'h2:    vec_c = evp_pkg::VEC_RST_COP;
        default: vec_c = evp_pkg::VEC_RST_POR;
      endcase
    end
  end

  assign d.vector  = vec_c;
  assign d.any_req = any_c;
endmodule // evp_prio_dec
`default_nettype wire

/* File: hw/evp_top.sv */
// Top of the exception vector priority unit with base register and fetch
`timescale 1ns/1ps
`default_nettype none
module evp_top (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic [56:0] irq_req,
  input  wire logic        xirq_req,
  input  wire logic        software_interrupt_request,
  input  wire logic        trap_req,
  input  wire logic        rst_req,
  input  wire logic [1:0]  rst_sel,
  input  wire logic        background_debug_mode,
  input  wire logic        base_wr,
  input  wire logic [7:0]  base_wdata,
  input  wire logic        vec_req,
  output logic [7:0]       vector_base_register,
  output logic [15:0]      vec_addr,
  output logic             vec_valid,
  output logic             wake_req
);
  evp_dec_if dif ();

  logic [7:0]          base_r;
  logic [7:0]          base_nxt;
  logic [15:0]         vec_r;
  logic [15:0]         vec_nxt;
  logic                valid_r;
  logic                valid_nxt;
  evp_pkg::evp_state_t state_r;
  evp_pkg::evp_state_t state_nxt;

  // Debug freeze substitutes a fixed base so debug firmware owns vectors
  assign dif.base     = background_debug_mode ? evp_pkg::BASE_DEBUG
                                              : base_r;
  assign dif.irq_req  = irq_req;
  assign dif.xirq_req = xirq_req;
  assign dif.swi_req  = software_interrupt_request;
  assign dif.trap_req = trap_req;
  assign dif.rst_req  = rst_req;
  assign dif.rst_sel  = rst_sel;

  evp_prio_dec u_dec (
    .d (dif.dec)
  );

  // Base register write path
  always_comb begin
    base_nxt = base_r;
    if (base_wr) begin
      base_nxt = base_wdata;
    end
  end

  // Vector captured on the request edge; later requests are re-decoded
  // afresh, so a handler in progress can be interrupted again
  always_comb begin
    vec_nxt   = vec_r;
    valid_nxt = 1'b0;
    state_nxt = state_r;
    case (state_r)
      evp_pkg::EVP_IDLE: begin
        if (vec_req) begin
          vec_nxt   = dif.vector;
          valid_nxt = 1'b1;
          state_nxt = evp_pkg::EVP_HOLD;
        end
      end
      evp_pkg::EVP_HOLD: begin
        // Wait for the request to drop before taking another
        if (!vec_req) begin
          state_nxt = evp_pkg::EVP_IDLE;
        end
      end
      default: state_nxt = evp_pkg::EVP_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      base_r  <= evp_pkg::BASE_RST;
      vec_r   <= evp_pkg::VEC_RST_VAL;
      valid_r <= 1'b0;
      state_r <= evp_pkg::EVP_IDLE;
    end else begin
      base_r  <= base_nxt;
      vec_r   <= vec_nxt;
      valid_r <= valid_nxt;
      state_r <= state_nxt;
    end
  end

  // Wake is combinational so it works while mclk is gated off
  assign wake_req = dif.any_req;

  assign vector_base_register = base_r;
  assign vec_addr             = vec_r;
  assign vec_valid            = valid_r;
endmodule // evp_top
`default_nettype wire

/* File: tb/evp_chk_asserts.sv */
// Checker on the vector unit top ports
`timescale 1ns/1ps
`default_nettype none
module evp_chk (
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic [56:0] irq_req,
  input wire logic        xirq_req,
  input wire logic        software_interrupt_request,
  input wire logic        trap_req,
  input wire logic        rst_req,
  input wire logic        background_debug_mode,
  input wire logic        base_wr,
  input wire logic [7:0]  base_wdata,
  input wire logic        vec_req,
  input wire logic [7:0]  vector_base_register,
  input wire logic [15:0] vec_addr,
  input wire logic        vec_valid,
  input wire logic        wake_req
);
  // Anything pending at all, reset included
  wire any_w = |{irq_req, xirq_req, software_interrupt_request, trap_req,
                 rst_req};
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  valid_pulse_a: assert property (vec_valid |=> !vec_valid)
    else $error("valid held too long");
  valid_cause_a: assert property (vec_valid |-> $past(vec_req))
    else $error("valid with no request");
  base_write_a: assert property (base_wr |=>
    vector_base_register == $past(base_wdata)) else $error("base not written");
  wake_any_a: assert property (wake_req == any_w)
    else $error("wake wrong");
  trap_vec_a: assert property ($rose(vec_req) && trap_req && !rst_req
    |=> vec_addr[7:0] == 8'hF8) else $error("trap not chosen");
  spur_vec_a: assert property ($rose(vec_req) && !any_w
    |=> vec_addr[7:0] == 8'h80) else $error("spurious wrong");
  dbg_base_a: assert property ($rose(vec_req) && background_debug_mode
    && !rst_req |=> vec_addr[15:8] == 8'hFF) else $error("debug base wrong");
  rst_vec_a: assert property ($rose(vec_req) && rst_req
    |=> vec_addr[15:4] == 12'hFFF) else $error("reset vector wrong");
endmodule // evp_chk
bind evp_top evp_chk evp_chk_i (.*);
`default_nettype wire

/* File: tb/evp_cpu.sv */
// Core model that fetches exception vectors
`timescale 1ns/1ps
`default_nettype none
module evp_cpu (
  input  wire logic        mclk,
  input  wire logic        vec_valid,
  input  wire logic [15:0] vec_addr,
  output logic             vec_req
);
  initial vec_req = 1'b0;
  // Hold the request past the answer, then idle so the next one is taken
  task automatic fetch(output logic [15:0] a);
    a = 'x;
    vec_req = 1'b1;
    repeat (3) begin
      @(negedge mclk);
      if (vec_valid === 1'b1) a = vec_addr;
    end
    vec_req = 1'b0;
    @(negedge mclk);
  endtask
endmodule // evp_cpu
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench of the exception vector priority unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        mclk, nrst, xq, sw, tr, rr, dbg, bw, vreq, vv, wk;
  logic [56:0] irq;
  logic [1:0]  rs;
  logic [7:0]  bd, vbr;
  logic [15:0] va, got;
  int          err_count = 0, compares = 0, cyc = 0, i;
  // Rows: requests, controls {x,swi,trap,rst,sel,dbg}, expected vector
  logic [56:0] t_irq [12] = '{57'h0, 57'h1, 57'h100000000000001, 57'h30,
    {57{1'b1}}, 57'h0, 57'h0, 57'h1, 57'h0, 57'h0, 57'h0, 57'h0};
  logic [6:0]  t_ctl [12] = '{7'h00, 7'h00, 7'h00, 7'h00, 7'h40, 7'h60,
    7'h30, 7'h01, 7'h18, 7'h0A, 7'h0C, 7'h0E};
  logic [15:0] t_exp [12] = '{16'h3C80, 16'h3C82, 16'h3CF2, 16'h3C8C,
    16'h3CF4, 16'h3CF6, 16'h3CF8, 16'hFF82, 16'hFFFE, 16'hFFFC, 16'hFFFA,
    16'hFFFE};
  evp_top evp_top_i (.mclk(mclk), .nrst(nrst), .irq_req(irq), .xirq_req(xq),
    .software_interrupt_request(sw), .trap_req(tr), .rst_req(rr),
    .rst_sel(rs), .background_debug_mode(dbg), .base_wr(bw),
    .base_wdata(bd), .vec_req(vreq), .vector_base_register(vbr),
    .vec_addr(va), .vec_valid(vv), .wake_req(wk));
  evp_cpu evp_cpu_i (.mclk(mclk), .vec_valid(vv), .vec_addr(va),
    .vec_req(vreq));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Cut a hang short well past the expected run length
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      end_sim;
    end
  end
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task end_sim;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {irq, xq, sw, tr, rr, rs, dbg, bw, bd} = '0;
    nrst = 1'b0;
    repeat (2) @(negedge mclk);
    nrst = 1'b1;
    chk("base", 16'h00FF, {8'h00, vbr});
    {bw, bd} = {1'b1, 8'h3C};
    @(negedge mclk);
    bw = 1'b0;
    chk("base", 16'h003C, {8'h00, vbr});
    // Each row re-decodes on a fresh fetch after the last one ends, so no request arrives mid-handler
    for (i = 0; i < 12; i++) begin
      irq = t_irq[i];
      {xq, sw, tr, rr, rs, dbg} = t_ctl[i];
      #1;
      chk("wake", {15'h0, |{irq, t_ctl[i][6:3]}}, {15'h0, wk});
      evp_cpu_i.fetch(got);
      chk("vector", t_exp[i], got);
    end
    // Mid-run reset must bring the base back to the top page
    {irq, xq, sw, tr, rr, rs, dbg, nrst} = '0;
    #1;
    chk("base", 16'h00FF, {8'h00, vbr});
    @(negedge mclk);
    nrst = 1'b1;
    evp_cpu_i.fetch(got);
    chk("vector", 16'hFF80, got);
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
